/* src/irq_map_pkg.sv */
/*
 * Shared constants, field layout and carrier types for the interrupt pin
 * mapping, buffer configuration and synthesizer divider block.
 * Assumes one 20 MHz clock for the block, its register port and its sources.
 */
package irq_map_pkg;

    // Register indices on the 4-bit register port
    localparam logic [3:0] ADDR_F1_REF = 4'h6;
    localparam logic [3:0] ADDR_F1_PRESCALE = 4'h7;
    localparam logic [3:0] ADDR_F1_SWALLOW = 4'h8;
    localparam logic [3:0] ADDR_F2_REF = 4'h9;
    localparam logic [3:0] ADDR_F2_PRESCALE = 4'ha;
    localparam logic [3:0] ADDR_F2_SWALLOW = 4'hb;
    localparam logic [3:0] ADDR_SIZE_THRESH = 4'hc;
    localparam logic [3:0] ADDR_PIN_ROUTING = 4'hd;

    // Reset values
    localparam logic [7:0] RST_F1_REF = 8'h6b;
    localparam logic [7:0] RST_F1_PRESCALE = 8'h2a;
    localparam logic [7:0] RST_F1_SWALLOW = 8'h1e;
    localparam logic [7:0] RST_F2_REF = 8'h77;
    localparam logic [7:0] RST_F2_PRESCALE = 8'h2f;
    localparam logic [7:0] RST_F2_SWALLOW = 8'h19;
    localparam logic [7:0] RST_SIZE_THRESH = 8'h0f;
    localparam logic [5:0] RST_ROUTING_CTL = 6'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Field positions
    localparam int SIZE_MSB = 7;
    localparam int SIZE_LSB = 6;
    localparam int THRESH_MSB = 5;
    localparam int THRESH_LSB = 0;
    localparam int RX_A_MSB = 7;
    localparam int RX_A_LSB = 6;
    localparam int RX_B_MSB = 5;
    localparam int RX_B_LSB = 4;
    localparam int TX_A_BIT = 3;
    localparam int TX_B_BIT = 2;
    localparam int FULL_BIT = 1;
    localparam int NOT_EMPTY_BIT = 0;

    // Buffer capacity grows in steps of this many bytes
    localparam logic [6:0] SIZE_STEP_BYTES = 7'h10;

    // Chip and data mode codes
    localparam logic [2:0] CHIP_STANDBY = 3'h1;
    localparam logic [2:0] CHIP_RECEIVE = 3'h3;
    localparam logic [2:0] CHIP_TRANSMIT = 3'h4;
    localparam logic [1:0] DATA_CONTINUOUS = 2'h0;
    localparam logic [1:0] DATA_BUFFERED = 2'h1;

    // Source selector codes
    localparam logic [1:0] SEL_0 = 2'h0;
    localparam logic [1:0] SEL_1 = 2'h1;
    localparam logic [1:0] SEL_2 = 2'h2;

    // Event levels coming from the modem and packet logic
    typedef struct packed {
        logic pattern;
        logic signal_level_irq;
        logic start_detect;
        logic write_byte;
        logic data_ready;
        logic node_match;
        logic crc_ok;
        logic recovered_bit_clock;
        logic tx_finished;
    } irq_events_t;

    // Divider set handed to the synthesizer
    typedef struct packed {
        logic [7:0] ref_count;
        logic [7:0] prescale_count;
        logic [7:0] swallow_count;
    } synth_divider_t;

    // Buffer status flags
    typedef struct packed {
        logic full;
        logic not_empty;
        logic thresh_hit;
    } buffer_flags_t;

    function automatic logic is_continuous(input logic [1:0] data_mode);
        return data_mode == DATA_CONTINUOUS;
    endfunction

    function automatic logic is_buffered(input logic [1:0] data_mode);
        return data_mode == DATA_BUFFERED;
    endfunction

endpackage

/* src/buffer_status.sv */
/*
 * Buffer status flags from fill level, size code and threshold.
 * Assumes the fill level is a same-clock count of bytes held.
 */
`timescale 1ns/100ps
module buffer_status (
    input wire logic [6:0] fill_count_in,
    input wire logic [1:0] size_code_in,
    input wire logic [5:0] thresh_code_in,
    output irq_map_pkg::buffer_flags_t flags_out
);
    logic [6:0] capacity;

    always_comb
    begin
        capacity = 7'(({5'h00, size_code_in} + 7'h01) * irq_map_pkg::SIZE_STEP_BYTES);
        flags_out.full = fill_count_in >= capacity;
        flags_out.not_empty = fill_count_in != 7'h00;
        flags_out.thresh_hit = fill_count_in > {1'b0, thresh_code_in};
    end
endmodule // buffer_status

/* src/pin_router.sv */
/*
 * Routes event sources onto the two host interrupt pins.
 * Assumes all sources are levels on the block clock.
 */
`timescale 1ns/100ps
module pin_router (
    input wire logic [2:0] chip_mode_in,
    input wire logic [1:0] data_mode_in,
    input wire logic [5:0] routing_ctl_in,
    input wire logic node_match_enable_in,
    input irq_map_pkg::irq_events_t events_in,
    input irq_map_pkg::buffer_flags_t flags_in,
    output logic pin_a_out,
    output logic pin_b_out
);
    logic [1:0] rx_a;
    logic [1:0] rx_b;
    logic tx_a;
    logic tx_b;
    logic rx_on;
    logic standby;
    logic a_val;
    logic a_sb;
    logic b_val;
    logic b_sb;

    always_comb
    begin
        rx_a = routing_ctl_in[5:4];
        rx_b = routing_ctl_in[3:2];
        tx_a = routing_ctl_in[1];
        tx_b = routing_ctl_in[0];
        rx_on = chip_mode_in == irq_map_pkg::CHIP_RECEIVE;
        standby = chip_mode_in == irq_map_pkg::CHIP_STANDBY;
        a_val = 1'b0;
        a_sb = 1'b0;
        b_val = 1'b0;
        b_sb = 1'b0;
        if (irq_map_pkg::is_continuous(data_mode_in))
        begin
            case (rx_a)
                irq_map_pkg::SEL_0: a_val = events_in.pattern;
                irq_map_pkg::SEL_1: a_val = events_in.signal_level_irq;
                default: a_val = events_in.start_detect;
            endcase
            b_val = events_in.recovered_bit_clock;
        end
        else if (irq_map_pkg::is_buffered(data_mode_in))
        begin
            case (rx_a)
                irq_map_pkg::SEL_0: a_val = 1'b0;
                irq_map_pkg::SEL_1: a_val = events_in.write_byte;
                irq_map_pkg::SEL_2:
                begin
                    a_val = flags_in.not_empty;
                    a_sb = 1'b1;
                end
                default: a_val = events_in.start_detect;
            endcase
            case (rx_b)
                irq_map_pkg::SEL_0: b_val = 1'b0;
                irq_map_pkg::SEL_1: b_val = flags_in.full;
                irq_map_pkg::SEL_2: b_val = events_in.signal_level_irq;
                default:
                begin
                    b_val = flags_in.thresh_hit;
                    b_sb = 1'b1;
                end
            endcase
        end
        else
        begin
            case (rx_a)
                irq_map_pkg::SEL_0: a_val = events_in.data_ready;
                irq_map_pkg::SEL_1: a_val = events_in.write_byte;
                irq_map_pkg::SEL_2:
                begin
                    a_val = flags_in.not_empty;
                    a_sb = 1'b1;
                end
                default: a_val = node_match_enable_in ? events_in.node_match : events_in.start_detect;
            endcase
            case (rx_b)
                irq_map_pkg::SEL_0: b_val = events_in.crc_ok;
                irq_map_pkg::SEL_1:
                begin
                    b_val = flags_in.full;
                    b_sb = 1'b1;
                end
                irq_map_pkg::SEL_2: b_val = events_in.signal_level_irq;
                default:
                begin
                    b_val = flags_in.thresh_hit;
                    b_sb = 1'b1;
                end
            endcase
        end
        pin_a_out = 1'b0;
        pin_b_out = 1'b0;
        if (rx_on || standby)
        begin
            pin_a_out = a_val && (rx_on || a_sb);
            pin_b_out = b_val && (rx_on || b_sb);
        end
        else if (chip_mode_in == irq_map_pkg::CHIP_TRANSMIT)
        begin
            if (irq_map_pkg::is_continuous(data_mode_in))
            begin
                pin_a_out = 1'b0;
                pin_b_out = events_in.recovered_bit_clock;
            end
            else
            begin
                pin_a_out = tx_a ? flags_in.not_empty : flags_in.thresh_hit;
                pin_b_out = tx_b ? events_in.tx_finished : flags_in.full;
            end
        end
    end
endmodule // pin_router

/* src/irq_pin_mapping.sv */
/*
 * Interrupt pin mapping, buffer size and threshold configuration, buffer
 * status flags and the two synthesizer divider sets, behind the register port.
 * Assumes the serial port decoder, modem and buffer all run on ref_clk_in,
 * and that chip mode, data mode and frequency select come from other registers.
 */
// How it works
// - First frequency dividers, resets 6b 2a 1e
// - Second frequency dividers, resets 77 2f 19
// - Select bit picks divider set one/two
// - Size field gives 16 to 64 bytes
// - Threshold equals field value plus one
// - Threshold sources assert at threshold fill
// - Continuous receive pin a source map
// - Buffered receive pin a source map
// - Packet receive pin a source map
// - Code 11 address match or start
// - Continuous receive pin b gives clock
// - Continuous transmit pin a held low
// - Transmit pin a threshold or not empty
// - Transmission starts on pin a rise
// - Continuous transmit pin b gives clock
// - Finished reads one after last bit
// - Read-only full flag, also a source
// - Read-only not-empty flag, also a source
`timescale 1ns/100ps
module irq_pin_mapping (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [2:0] chip_mode_in,
    input wire logic [1:0] data_mode_in,
    input wire logic frequency_select_in,
    input wire logic node_match_enable_in,
    input wire logic [6:0] fill_count_in,
    input irq_map_pkg::irq_events_t events_in,
    output logic [7:0] reg_rdata_out,
    output irq_map_pkg::synth_divider_t synth_divider_out,
    output logic host_irq_a_out,
    output logic host_irq_b_out,
    output logic tx_start_out
);
    logic [7:0] freq1_ref_reg;
    logic [7:0] freq1_prescale_reg;
    logic [7:0] freq1_swallow_reg;
    logic [7:0] freq2_ref_reg;
    logic [7:0] freq2_prescale_reg;
    logic [7:0] freq2_swallow_reg;
    logic [7:0] size_thresh_reg;
    logic [5:0] routing_ctl_reg;
    logic [7:0] rdata_next;
    logic pin_a_next;
    logic pin_b_next;
    logic tx_start_next;
    logic tx_fifo_mode;
    irq_map_pkg::buffer_flags_t flags;
    irq_map_pkg::synth_divider_t divider_next;

    buffer_status status_unit (
        .fill_count_in(fill_count_in),
        .size_code_in(size_thresh_reg[irq_map_pkg::SIZE_MSB:irq_map_pkg::SIZE_LSB]),
        .thresh_code_in(size_thresh_reg[irq_map_pkg::THRESH_MSB:irq_map_pkg::THRESH_LSB]),
        .flags_out(flags)
    );

    pin_router router_unit (
        .chip_mode_in(chip_mode_in),
        .data_mode_in(data_mode_in),
        .routing_ctl_in(routing_ctl_reg),
        .node_match_enable_in(node_match_enable_in),
        .events_in(events_in),
        .flags_in(flags),
        .pin_a_out(pin_a_next),
        .pin_b_out(pin_b_next)
    );

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            freq1_ref_reg <= irq_map_pkg::RST_F1_REF;
            freq1_prescale_reg <= irq_map_pkg::RST_F1_PRESCALE;
            freq1_swallow_reg <= irq_map_pkg::RST_F1_SWALLOW;
        end
        else if (reg_write_in)
        begin
            if (reg_addr_in == irq_map_pkg::ADDR_F1_REF)
                freq1_ref_reg <= reg_wdata_in;
            if (reg_addr_in == irq_map_pkg::ADDR_F1_PRESCALE)
                freq1_prescale_reg <= reg_wdata_in;
            if (reg_addr_in == irq_map_pkg::ADDR_F1_SWALLOW)
                freq1_swallow_reg <= reg_wdata_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            freq2_ref_reg <= irq_map_pkg::RST_F2_REF;
            freq2_prescale_reg <= irq_map_pkg::RST_F2_PRESCALE;
            freq2_swallow_reg <= irq_map_pkg::RST_F2_SWALLOW;
        end
        else if (reg_write_in)
        begin
            if (reg_addr_in == irq_map_pkg::ADDR_F2_REF)
                freq2_ref_reg <= reg_wdata_in;
            if (reg_addr_in == irq_map_pkg::ADDR_F2_PRESCALE)
                freq2_prescale_reg <= reg_wdata_in;
            if (reg_addr_in == irq_map_pkg::ADDR_F2_SWALLOW)
                freq2_swallow_reg <= reg_wdata_in;
        end
    end

    // Size, threshold and routing selectors; flag bits are not stored
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            size_thresh_reg <= irq_map_pkg::RST_SIZE_THRESH;
            routing_ctl_reg <= irq_map_pkg::RST_ROUTING_CTL;
        end
        else if (reg_write_in)
        begin
            if (reg_addr_in == irq_map_pkg::ADDR_SIZE_THRESH)
                size_thresh_reg <= reg_wdata_in;
            if (reg_addr_in == irq_map_pkg::ADDR_PIN_ROUTING)
                routing_ctl_reg <= reg_wdata_in[irq_map_pkg::RX_A_MSB:irq_map_pkg::TX_B_BIT];
        end
    end

    always_comb
    begin
        rdata_next = irq_map_pkg::READ_UNMAPPED;
        case (reg_addr_in)
            irq_map_pkg::ADDR_F1_REF: rdata_next = freq1_ref_reg;
            irq_map_pkg::ADDR_F1_PRESCALE: rdata_next = freq1_prescale_reg;
            irq_map_pkg::ADDR_F1_SWALLOW: rdata_next = freq1_swallow_reg;
            irq_map_pkg::ADDR_F2_REF: rdata_next = freq2_ref_reg;
            irq_map_pkg::ADDR_F2_PRESCALE: rdata_next = freq2_prescale_reg;
            irq_map_pkg::ADDR_F2_SWALLOW: rdata_next = freq2_swallow_reg;
            irq_map_pkg::ADDR_SIZE_THRESH: rdata_next = size_thresh_reg;
            irq_map_pkg::ADDR_PIN_ROUTING: rdata_next = {routing_ctl_reg, flags.full, flags.not_empty};
            default: rdata_next = irq_map_pkg::READ_UNMAPPED;
        endcase
    end

    // Read data holds until the next read
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            reg_rdata_out <= irq_map_pkg::READ_UNMAPPED;
        else if (reg_read_in)
            reg_rdata_out <= rdata_next;
    end

    always_comb
    begin
        if (frequency_select_in)
            divider_next = '{freq2_ref_reg, freq2_prescale_reg, freq2_swallow_reg};
        else
            divider_next = '{freq1_ref_reg, freq1_prescale_reg, freq1_swallow_reg};
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            synth_divider_out <= '{irq_map_pkg::RST_F1_REF, irq_map_pkg::RST_F1_PRESCALE,
                irq_map_pkg::RST_F1_SWALLOW};
        else
            synth_divider_out <= divider_next;
    end

    // Pins registered, so the bit clock on pin b lags by one cycle
    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            host_irq_a_out <= 1'b0;
            host_irq_b_out <= 1'b0;
        end
        else
        begin
            host_irq_a_out <= pin_a_next;
            host_irq_b_out <= pin_b_next;
        end
    end

    assign tx_fifo_mode = (chip_mode_in == irq_map_pkg::CHIP_TRANSMIT)
        && !irq_map_pkg::is_continuous(data_mode_in);
    assign tx_start_next = tx_fifo_mode && pin_a_next && !host_irq_a_out;

    always_ff @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            tx_start_out <= 1'b0;
        else
            tx_start_out <= tx_start_next;
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_freq1_write: assert property (
        reg_write_in && reg_addr_in == irq_map_pkg::ADDR_F1_PRESCALE
        |=> freq1_prescale_reg == $past(reg_wdata_in))
        else $error("freq1 prescale write lost");

    a_freq2_write: assert property (
        reg_write_in && reg_addr_in == irq_map_pkg::ADDR_F2_SWALLOW
        |=> freq2_swallow_reg == $past(reg_wdata_in))
        else $error("freq2 swallow write lost");

    a_divider_select: assert property (
        frequency_select_in && !reg_write_in |=> synth_divider_out.ref_count == freq2_ref_reg)
        else $error("divider set not from second frequency");

    a_size_capacity: assert property (
        size_thresh_reg[7:6] == 2'h1 && fill_count_in == 7'h1f |-> !flags.full)
        else $error("full flag early for 32 byte size");

    a_size_full: assert property (
        size_thresh_reg[7:6] == 2'h2 && fill_count_in == 7'h30 |-> flags.full)
        else $error("full flag missing at 48 bytes");

    a_thresh_level: assert property (
        fill_count_in == 7'(size_thresh_reg[5:0]) + 7'h01 |-> flags.thresh_hit)
        else $error("threshold not reached at value plus one");

    a_tx_cont_low: assert property (
        chip_mode_in == irq_map_pkg::CHIP_TRANSMIT && data_mode_in == irq_map_pkg::DATA_CONTINUOUS
        |=> !host_irq_a_out)
        else $error("pin a not low in continuous transmit");

    a_tx_clock_b: assert property (
        chip_mode_in == irq_map_pkg::CHIP_TRANSMIT && data_mode_in == irq_map_pkg::DATA_CONTINUOUS
        |=> host_irq_b_out == $past(events_in.recovered_bit_clock))
        else $error("pin b not carrying data clock");

    a_rx_clock_b: assert property (
        chip_mode_in == irq_map_pkg::CHIP_RECEIVE && data_mode_in == irq_map_pkg::DATA_CONTINUOUS
        |=> host_irq_b_out == $past(events_in.recovered_bit_clock))
        else $error("pin b not carrying recovered clock");

    a_tx_start_edge: assert property (
        tx_start_out |-> host_irq_a_out && !$past(host_irq_a_out))
        else $error("start pulse without pin a rise");

    a_empty_readback: assert property (
        reg_read_in && reg_addr_in == irq_map_pkg::ADDR_PIN_ROUTING
        |=> reg_rdata_out[0] == ($past(fill_count_in) != 7'h00))
        else $error("not-empty flag readback wrong");

    a_full_readback: assert property (
        reg_read_in && reg_addr_in == irq_map_pkg::ADDR_PIN_ROUTING && size_thresh_reg[7:6] == 2'h0
        |=> reg_rdata_out[1] == ($past(fill_count_in) >= 7'h10))
        else $error("full flag readback wrong");

    a_thresh_below: assert property (
        fill_count_in <= {1'b0, size_thresh_reg[5:0]}
        |-> !flags.thresh_hit)
        else $error("threshold source early");

    a_sleep_low: assert property (
        chip_mode_in == 3'h0
        |=> !host_irq_a_out && !host_irq_b_out)
        else $error("pins active in sleep");

    a_tx_not_empty: assert property (
        tx_fifo_mode && routing_ctl_reg[1]
        |=> host_irq_a_out == ($past(fill_count_in) != 7'h00))
        else $error("pin a not showing not-empty");

    a_tx_finished: assert property (
        tx_fifo_mode && routing_ctl_reg[0]
        |=> host_irq_b_out == $past(events_in.tx_finished))
        else $error("pin b not showing finished");

    a_standby_full: assert property (
        chip_mode_in == irq_map_pkg::CHIP_STANDBY && irq_map_pkg::is_buffered(data_mode_in)
        && routing_ctl_reg[3:2] == 2'h1
        |=> !host_irq_b_out)
        else $error("full flag on pin b in standby");

    c_tx_start: cover property (tx_start_out);
    c_buffer_full: cover property (flags.full ##1 !flags.full);
    c_freq_switch: cover property (!frequency_select_in ##1 frequency_select_in);
    c_standby_pin: cover property (chip_mode_in == irq_map_pkg::CHIP_STANDBY && host_irq_a_out);
endmodule // irq_pin_mapping

/* bench/host_mcu_model.sv */
/*
 * Host controller model: register writes and reads, counts pin a rises.
 * Assumes callers enter its tasks just after a rising clock edge.
 */
`timescale 1ns/100ps
module host_mcu_model (
    input wire logic ref_clk_in,
    input wire logic host_irq_a_in,
    input wire logic host_irq_b_in,
    output logic [3:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_write_out,
    output logic reg_read_out,
    output int a_rises_out
);
    logic a_prev = 1'b0;

    initial
    begin
        reg_addr_out = 4'h0;
        reg_wdata_out = 8'h00;
        reg_write_out = 1'b0;
        reg_read_out = 1'b0;
    end

    always @(posedge ref_clk_in)
    begin
        if (host_irq_a_in === 1'b1 && a_prev === 1'b0)
            a_rises_out <= a_rises_out + 1;
        a_prev <= host_irq_a_in;
    end

    task automatic wr(input logic [3:0] addr, input logic [7:0] data);
        @(posedge ref_clk_in);
        #2;
        reg_addr_out = addr;
        reg_wdata_out = data;
        reg_write_out = 1'b1;
        @(posedge ref_clk_in);
        #2;
        reg_write_out = 1'b0;
        // Idle data inverted so a stale byte never looks fresh
        reg_wdata_out = ~data;
    endtask

    task automatic rd(input logic [3:0] addr);
        @(posedge ref_clk_in);
        #2;
        reg_addr_out = addr;
        reg_read_out = 1'b1;
        @(posedge ref_clk_in);
        #2;
        reg_read_out = 1'b0;
    endtask
endmodule // host_mcu_model

/* bench/irq_pin_mapping_tb.sv */
/*
 * Self-checking bench for irq_pin_mapping driven through a host model.
 * Assumes the package and design files are compiled first.
 */
`timescale 1ns/100ps
module irq_pin_mapping_tb;
    logic ref_clk_in, reset_n_in, frequency_select_in, node_match_enable_in;
    logic [2:0] chip_mode_in;
    logic [1:0] data_mode_in;
    logic [6:0] fill_count_in;
    irq_map_pkg::irq_events_t events_in;
    irq_map_pkg::synth_divider_t divider;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic reg_write, reg_read, irq_a, irq_b, tx_start;
    int a_rises, n, n_fail = 0, checks_done = 0;
    logic [15:0] lfsr = 16'h0034;
    logic [7:0] exp_q[$];
    logic [7:0] wv [16];
    logic [7:0] rst_tab [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h6b, 8'h2a,
        8'h1e, 8'h77, 8'h2f, 8'h19, 8'h0f, 8'h00, 8'h00, 8'h00};
    logic [5:0] thr_tab [3] = '{6'h00, 6'h1f, 6'h3f};
    logic [2:0] cm_tab [5] = '{3'h3, 3'h1, 3'h4, 3'h0, 3'h2};

    irq_pin_mapping irq_pin_mapping_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_write_in(reg_write),
        .reg_read_in(reg_read), .chip_mode_in(chip_mode_in), .data_mode_in(data_mode_in),
        .frequency_select_in(frequency_select_in), .node_match_enable_in(node_match_enable_in),
        .fill_count_in(fill_count_in), .events_in(events_in), .reg_rdata_out(reg_rdata),
        .synth_divider_out(divider), .host_irq_a_out(irq_a), .host_irq_b_out(irq_b),
        .tx_start_out(tx_start));
    host_mcu_model host_mcu_model_inst (.ref_clk_in(ref_clk_in), .host_irq_a_in(irq_a),
        .host_irq_b_in(irq_b), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
        .reg_write_out(reg_write), .reg_read_out(reg_read), .a_rises_out(a_rises));

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [1:0] pins_exp(input logic [2:0] cm, input logic [1:0] dm, input logic [5:0] c,
        input logic nme, input irq_map_pkg::irq_events_t e, input logic full, input logic ne, input logic th);
        logic [3:0] av, bv;
        logic a, b;
        av = {e.start_detect, e.start_detect, e.signal_level_irq, e.pattern};
        bv = {4{e.recovered_bit_clock}};
        if (dm == 2'h1)
        begin
            av = {e.start_detect, ne, e.write_byte, 1'b0};
            bv = {th, e.signal_level_irq, full, 1'b0};
        end
        else if (dm[1])
        begin
            av = {nme ? e.node_match : e.start_detect, ne, e.write_byte, e.data_ready};
            bv = {th, e.signal_level_irq, full, e.crc_ok};
        end
        a = av[c[5:4]];
        b = bv[c[3:2]];
        if (cm == irq_map_pkg::CHIP_STANDBY)
        begin
            a = a & (dm != 2'h0) & (c[5:4] == 2'h2);
            b = b & (dm != 2'h0) & c[2] & (c[3] | dm[1]);
        end
        else if (cm == irq_map_pkg::CHIP_TRANSMIT)
        begin
            a = (dm != 2'h0) & (c[1] ? ne : th);
            b = (dm == 2'h0) ? e.recovered_bit_clock : (c[0] ? e.tx_finished : full);
        end
        else if (cm != irq_map_pkg::CHIP_RECEIVE)
            {a, b} = 2'b00;
        return {a, b};
    endfunction

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic do_read(input logic [3:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        host_mcu_model_inst.rd(addr);
    endtask

    task automatic settle;
        repeat (2) @(posedge ref_clk_in);
        #2;
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        ref_clk_in = 1'b0;
        forever
            #25 ref_clk_in = ~ref_clk_in;
    end

    // Read data is compared the cycle after the strobe is taken
    initial
    begin
        forever
        begin
            @(posedge ref_clk_in);
            if (reg_read === 1'b1)
            begin
                @(posedge ref_clk_in);
                #1;
                chk("read data", {16'h0000, exp_q.pop_front()}, {16'h0000, reg_rdata});
            end
        end
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk_in);
        n_fail++;
        test_done();
    end

    initial
    begin
        reset_n_in = 1'b0;
        chip_mode_in = irq_map_pkg::CHIP_STANDBY;
        data_mode_in = 2'h0;
        frequency_select_in = 1'b0;
        node_match_enable_in = 1'b0;
        fill_count_in = 7'h00;
        events_in = '0;
        repeat (12) @(posedge ref_clk_in);
        #2 reset_n_in = 1'b1;
        for (int i = 0; i < 16; i++)
            do_read(4'(i), rst_tab[i]);
        settle();
        chk("divider set one", {8'h6b, 8'h2a, 8'h1e}, divider);
        frequency_select_in = 1'b1;
        settle();
        chk("divider set two", {8'h77, 8'h2f, 8'h19}, divider);
        $display("reset values done");
        for (int i = 6; i < 12; i++)
        begin
            lfsr = lfsr_next(lfsr);
            wv[i] = lfsr[7:0];
            host_mcu_model_inst.wr(4'(i), wv[i]);
            do_read(4'(i), wv[i]);
        end
        host_mcu_model_inst.wr(4'he, 8'ha5);
        do_read(4'he, 8'h00);
        lfsr = lfsr_next(lfsr);
        host_mcu_model_inst.wr(4'hd, lfsr[7:0]);
        do_read(4'hd, {lfsr[7:2], 2'b00});
        for (int s = 0; s < 4; s++)
            for (int f = 0; f < 2; f++)
            begin
                host_mcu_model_inst.wr(4'hc, {2'(s), 6'h3f});
                fill_count_in = 7'((s + 1) * 16 - 1 + f);
                do_read(4'hd, {lfsr[7:2], 1'(f), 1'b1});
            end
        $display("register access done");
        chip_mode_in = irq_map_pkg::CHIP_TRANSMIT;
        data_mode_in = irq_map_pkg::DATA_BUFFERED;
        host_mcu_model_inst.wr(4'hd, 8'h00);
        foreach (thr_tab[k])
        begin
            host_mcu_model_inst.wr(4'hc, {2'b11, thr_tab[k]});
            fill_count_in = {1'b0, thr_tab[k]};
            settle();
            chk("pins below threshold", 24'h0, {irq_a, irq_b});
            n = a_rises;
            fill_count_in = 7'(thr_tab[k] + 1);
            @(posedge ref_clk_in);
            #2;
            chk("start pulse", 24'h3, {irq_a, tx_start});
            @(posedge ref_clk_in);
            #2;
            chk("start pulse end", 24'h2, {irq_a, tx_start});
            chk("host rise count", 24'h1, 24'(a_rises - n));
        end
        $display("threshold start done");
        host_mcu_model_inst.wr(4'hc, 8'h89);
        foreach (cm_tab[m])
            for (int d = 0; d < 4; d++)
                for (int c = 0; c < 64; c++)
                begin
                    lfsr = lfsr_next(lfsr);
                    host_mcu_model_inst.wr(4'hd, {6'(c), lfsr[1:0]});
                    chip_mode_in = cm_tab[m];
                    data_mode_in = 2'(d);
                    events_in = lfsr[15:7];
                    node_match_enable_in = lfsr[2];
                    frequency_select_in = lfsr[3];
                    fill_count_in = 7'(lfsr[6:0] % 65);
                    settle();
                    chk("pins", pins_exp(cm_tab[m], 2'(d), 6'(c), lfsr[2], events_in, fill_count_in >= 7'd48,
                        fill_count_in != 7'd0, fill_count_in >= 7'd10), {irq_a, irq_b});
                    chk("divider", lfsr[3] ? {wv[9], wv[10], wv[11]} : {wv[6], wv[7], wv[8]}, divider);
                end
        $display("pin routing done");
        settle();
        test_done();
    end
endmodule // irq_pin_mapping_tb
